// File: hdl/pin_mux_pkg.sv
// Constants shared by the pin multiplex and wake-up logic
//------------------------------------------------------------
// Overview of operation
// R1: Infrared transmit pins reset as driven-low outputs.
// R2: Switched-plane alternates tristate while main power is bad.
// R3: Fixed-edge wake pins fire on both edges, masked.
// R4: Programmable wake pins fire on selected edge, masked.
// R5: General io three interrupts only, mask bit three.
// R6: Embedded sci output driven by hardware or software.
// R7: Out zero, io seven push-pull or open-drain selectable.
// R8: Clock select low crystal, high single-ended input.
// R9: Scan out thirteen as io eighteen never wakes.
// R10: Keyboard reset needs floppy-select bit inactive.
// R11: Mux bits clear route default, set route alternate.
// R12: Default output pins drive their output register.
//------------------------------------------------------------
package pin_mux_pkg;
    // Widths of the wake-up groups
    localparam int FIXED_WAKE_W = 4;
    localparam int PROG_WAKE_W  = 4;
    // Bit of the second interrupt mask that gates io three
    localparam int IO3_MASK_BIT = 3;
    // Output register bits per default-function pin
    localparam int OUT_IR    = 0;
    localparam int OUT_MULTI = 1;
    localparam int OUT_ZERO  = 2;
    localparam int OUT_IO7   = 3;
    // Register addresses (8-bit word each)
    localparam logic [3:0] ADDR_MUX       = 4'h0;
    localparam logic [3:0] ADDR_OUT       = 4'h1;
    localparam logic [3:0] ADDR_WAKE_MASK = 4'h2;
    localparam logic [3:0] ADDR_EDGE_SEL  = 4'h3;
    localparam logic [3:0] ADDR_INT_MASK  = 4'h4;
    localparam logic [3:0] ADDR_STATUS    = 4'h5;
    localparam logic [3:0] ADDR_CLEAR     = 4'h6;
    localparam logic [3:0] ADDR_IRQ_EN    = 4'h7;
    localparam logic [3:0] ADDR_SCI       = 4'h8;
    localparam logic [3:0] ADDR_PIN_IN    = 4'h9;
    // Multiplex register fields
    localparam int MUX_INFRARED_TRANSMIT      = 0;
    localparam int MUX_FLOPPY    = 1;
    localparam int MUX_KEYBOARD_RESET_OUT     = 2;
    localparam int MUX_IO18      = 3;
    localparam int MUX_OD_GENERAL_OUT_ZERO   = 4;
    localparam int MUX_OD_IO7    = 5;
    localparam int MUX_ALT_VCC2  = 6;
    // Status register fields
    localparam int ST_FIXED = 0;
    localparam int ST_PROG  = 1;
    localparam int ST_IO3   = 2;
    localparam int ST_IO18  = 3;
    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
endpackage

// File: hdl/edge_detect.sv
// Per-bit edge detector with rise, fall or both selection
module edge_detect #(
    parameter int W = 4
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_reset,
    input  wire logic [W-1:0] i_level,
    input  wire logic [W-1:0] i_rise_en,
    input  wire logic [W-1:0] i_fall_en,
    output logic      [W-1:0] o_event
);
    // Previous sample of each input
    logic [W-1:0] prev_q;

    //------------------------------------------------------------
    // Sampling
    //------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            prev_q <= i_level; // Track the pin so release shows no false edge
        end else begin
            prev_q <= i_level;
        end
    end

    // One edge term per bit
    for (genvar g = 0; g < W; g++) begin : g_bit
        assign o_event[g] = (i_rise_en[g] & i_level[g] & ~prev_q[g]) |
                            (i_fall_en[g] & ~i_level[g] & prev_q[g]);
    end
endmodule

// File: hdl/event_status.sv
// Sticky status bits with write-one clear and enable gating
module event_status #(
    parameter int W = 4
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_reset,
    input  wire logic [W-1:0] i_set,
    input  wire logic [W-1:0] i_clear,
    input  wire logic [W-1:0] i_enable,
    output logic      [W-1:0] o_status,
    output logic              o_irq
);
    // Sticky bits
    logic [W-1:0] status_q;

    //------------------------------------------------------------
    // Set beats clear in the same cycle
    //------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~i_clear) | i_set;
        end
    end

    assign o_status = status_q;
    assign o_irq    = |(status_q & i_enable);
endmodule

// File: hdl/pin_function_mux_wakeup.sv
// Pin multiplex, power-good tristate and wake-up event logic
module pin_function_mux_wakeup #(
    parameter int FW = pin_mux_pkg::FIXED_WAKE_W,
    parameter int PW = pin_mux_pkg::PROG_WAKE_W
) (
    input  wire logic          i_ref_clk,
    input  wire logic          i_reset,
    // Register port
    input  wire logic [3:0]    i_addr,
    input  wire logic [7:0]    i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output logic      [7:0]    o_rdata,
    // Power and clock source
    input  wire logic          i_main_power_good,
    input  wire logic          i_rtc_clock_source_select,
    input  wire logic          i_crystal_in,
    input  wire logic          i_crystal_out_or_clock_in,
    output logic               o_rtc_clk,
    output logic               o_crystal_out,
    output logic               o_crystal_out_oe,
    // Infrared transmit pin
    input  wire logic          i_infrared_transmit_alt,
    output logic               o_infrared_transmit,
    output logic               o_infrared_transmit_oe,
    // Pin with floppy-select and keyboard reset alternates
    input  wire logic          i_floppy_select_alt,
    input  wire logic          i_keyboard_reset_out,
    output logic               o_multi_pin,
    output logic               o_multi_pin_oe,
    // Push-pull or open-drain outputs
    input  wire logic          i_general_io_seven,
    output logic               o_general_out_zero,
    output logic               o_general_out_zero_oe,
    output logic               o_general_io_seven,
    output logic               o_general_io_seven_oe,
    // Wake-up inputs
    input  wire logic [FW-1:0] i_fixed_wake,
    input  wire logic [PW-1:0] i_prog_wake,
    input  wire logic          i_general_io_three,
    input  wire logic          i_scan_out_thirteen,
    output logic      [FW-1:0] o_scan_io_in,
    // Hardware event source for the sci output
    input  wire logic          i_sci_hw_event,
    output logic               o_embedded_sci_out_n,
    output logic               o_wake,
    output logic               o_irq
);
    // Wake groups must fit the 8-bit mask and edge select registers
    if (FW < 1 || FW > 8 || PW < 1 || PW > 8) begin : g_bad_width
        $error("wake group width must be 1 to 8");
    end

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    logic [7:0]    mux_q;        // Multiplex control bits
    logic [7:0]    out_q;        // General output register
    logic [7:0]    wake_mask_q;  // Wake-up mask, fixed low, prog high
    logic [7:0]    edge_sel_q;   // 1 rise, 0 fall per prog pin
    logic [7:0]    int_mask_q;   // Second interrupt mask
    logic [3:0]    irq_en_q;     // Interrupt enables
    logic          sci_sw_q;     // Software sci assert
    logic [7:0]    rdata_q;      // Read data
    logic [3:0]    clear_pulse;  // Write-one clear
    logic [3:0]    status;       // Sticky status
    logic [FW-1:0] fixed_ev;     // Fixed group edges
    logic [PW-1:0] prog_ev;      // Prog group edges
    logic [1:0]    misc_ev;      // io three and io eighteen edges
    logic [3:0]    set_vec;      // Status set terms
    logic [FW-1:0] fixed_wake_en;
    logic [PW-1:0] prog_rise, prog_fall, prog_mask;
    logic          io3_int, io18_is_sel;

    // Register writes
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            mux_q       <= pin_mux_pkg::RST_ZERO; // R1
            out_q       <= pin_mux_pkg::RST_ZERO; // R1
            wake_mask_q <= pin_mux_pkg::RST_ZERO;
            edge_sel_q  <= pin_mux_pkg::RST_ZERO;
            int_mask_q  <= pin_mux_pkg::RST_ZERO;
            irq_en_q    <= 4'h0;
            sci_sw_q    <= 1'b0;
        end else if (i_wr) begin
            case (i_addr)
                pin_mux_pkg::ADDR_MUX:       mux_q       <= i_wdata;
                pin_mux_pkg::ADDR_OUT:       out_q       <= i_wdata;
                pin_mux_pkg::ADDR_WAKE_MASK: wake_mask_q <= i_wdata;
                pin_mux_pkg::ADDR_EDGE_SEL:  edge_sel_q  <= i_wdata;
                pin_mux_pkg::ADDR_INT_MASK:  int_mask_q  <= i_wdata;
                pin_mux_pkg::ADDR_IRQ_EN:    irq_en_q    <= i_wdata[3:0];
                pin_mux_pkg::ADDR_SCI:       sci_sw_q    <= i_wdata[0];
                default: ;
            endcase
        end
    end

    // Clear strobe only on a write to the clear address
    assign clear_pulse = (i_wr && i_addr == pin_mux_pkg::ADDR_CLEAR) ? i_wdata[3:0] : 4'h0;

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            rdata_q <= pin_mux_pkg::RST_ZERO;
        end else if (i_rd) begin
            case (i_addr)
                pin_mux_pkg::ADDR_MUX:       rdata_q <= mux_q;
                pin_mux_pkg::ADDR_OUT:       rdata_q <= out_q;
                pin_mux_pkg::ADDR_WAKE_MASK: rdata_q <= wake_mask_q;
                pin_mux_pkg::ADDR_EDGE_SEL:  rdata_q <= edge_sel_q;
                pin_mux_pkg::ADDR_INT_MASK:  rdata_q <= int_mask_q;
                pin_mux_pkg::ADDR_STATUS:    rdata_q <= {4'h0, status};
                pin_mux_pkg::ADDR_IRQ_EN:    rdata_q <= {4'h0, irq_en_q};
                pin_mux_pkg::ADDR_SCI:       rdata_q <= {7'h00, sci_sw_q};
                pin_mux_pkg::ADDR_PIN_IN:    rdata_q <= {4'h0, i_main_power_good,
                                                 i_rtc_clock_source_select,
                                                 i_general_io_three, i_general_io_seven};
                default:                     rdata_q <= pin_mux_pkg::RST_ZERO;
            endcase
        end else begin
            rdata_q <= pin_mux_pkg::RST_ZERO;
        end
    end
    assign o_rdata = rdata_q;

    //------------------------------------------------------------
    // Pin outputs
    //------------------------------------------------------------
    // Infrared transmit: default drives output register bit, alternate on switched plane
    always_comb begin
        if (mux_q[pin_mux_pkg::MUX_INFRARED_TRANSMIT]) begin
            o_infrared_transmit    = i_infrared_transmit_alt; // R11
            o_infrared_transmit_oe = i_main_power_good;       // R2
        end else begin
            o_infrared_transmit    = out_q[pin_mux_pkg::OUT_IR]; // R1 R12
            o_infrared_transmit_oe = 1'b1;                    // R1
        end
    end

    // Floppy select takes priority; keyboard reset only when it is off
    always_comb begin
        if (mux_q[pin_mux_pkg::MUX_FLOPPY]) begin
            o_multi_pin    = i_floppy_select_alt;   // R11
            o_multi_pin_oe = i_main_power_good;     // R2
        end else if (mux_q[pin_mux_pkg::MUX_KEYBOARD_RESET_OUT]) begin
            o_multi_pin    = i_keyboard_reset_out;  // R10
            o_multi_pin_oe = i_main_power_good;     // R2
        end else begin
            o_multi_pin    = out_q[pin_mux_pkg::OUT_MULTI]; // R12
            o_multi_pin_oe = 1'b1;
        end
    end

    // Out zero: push-pull, or open-drain driving only low
    assign o_general_out_zero    = out_q[pin_mux_pkg::OUT_ZERO];                       // R12
    assign o_general_out_zero_oe = ~mux_q[pin_mux_pkg::MUX_OD_GENERAL_OUT_ZERO]
                                 | ~out_q[pin_mux_pkg::OUT_ZERO];                      // R7
    assign o_general_io_seven    = out_q[pin_mux_pkg::OUT_IO7];                        // R12
    assign o_general_io_seven_oe = ~mux_q[pin_mux_pkg::MUX_OD_IO7]
                                 | ~out_q[pin_mux_pkg::OUT_IO7];                       // R7

    // Real-time clock source
    assign o_rtc_clk        = i_rtc_clock_source_select ? i_crystal_out_or_clock_in
                                                        : i_crystal_in;               // R8
    assign o_crystal_out    = ~i_crystal_in;
    assign o_crystal_out_oe = ~i_rtc_clock_source_select;                             // R8

    // Scan out thirteen input seen as io eighteen when selected
    assign io18_is_sel  = mux_q[pin_mux_pkg::MUX_IO18];
    assign o_scan_io_in = i_fixed_wake;

    //------------------------------------------------------------
    // Wake-up events
    //------------------------------------------------------------
    assign fixed_wake_en = wake_mask_q[FW-1:0];
    assign prog_mask     = wake_mask_q[7 -: PW];
    assign prog_rise     = prog_mask & edge_sel_q[PW-1:0];    // R4
    assign prog_fall     = prog_mask & ~edge_sel_q[PW-1:0];   // R4

    edge_detect #(.W(FW)) u_fixed (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_level   (i_fixed_wake),
        .i_rise_en (fixed_wake_en),  // R3
        .i_fall_en (fixed_wake_en),  // R3
        .o_event   (fixed_ev)
    );

    edge_detect #(.W(PW)) u_prog (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_level   (i_prog_wake),
        .i_rise_en (prog_rise),
        .i_fall_en (prog_fall),
        .o_event   (prog_ev)
    );

    // io three gated by its interrupt mask; io eighteen seen but never wakes
    edge_detect #(.W(2)) u_misc (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_level   ({i_scan_out_thirteen, i_general_io_three}),
        .i_rise_en ({io18_is_sel, int_mask_q[pin_mux_pkg::IO3_MASK_BIT]}), // R5
        .i_fall_en ({io18_is_sel, int_mask_q[pin_mux_pkg::IO3_MASK_BIT]}), // R5
        .o_event   (misc_ev)
    );
    assign io3_int = misc_ev[0];

    always_comb begin
        set_vec                       = 4'h0;
        set_vec[pin_mux_pkg::ST_FIXED] = |fixed_ev;
        set_vec[pin_mux_pkg::ST_PROG]  = |prog_ev;
        set_vec[pin_mux_pkg::ST_IO3]   = io3_int;
        set_vec[pin_mux_pkg::ST_IO18]  = misc_ev[1];
    end

    event_status #(.W(4)) u_status (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_set     (set_vec),
        .i_clear   (clear_pulse),
        .i_enable  (irq_en_q),
        .o_status  (status),
        .o_irq     (o_irq)
    );

    // Only fixed and prog groups wake; io three and io eighteen excluded
    assign o_wake = status[pin_mux_pkg::ST_FIXED] | status[pin_mux_pkg::ST_PROG]; // R5 R9

    // Sci driven by hardware event or software, active low
    assign o_embedded_sci_out_n = ~(i_sci_hw_event | sci_sw_q);                    // R6

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    sequence io3_edge_s;
        int_mask_q[pin_mux_pkg::IO3_MASK_BIT] && $changed(i_general_io_three);
    endsequence

    ir_reset_low_a: assert property (@(posedge i_ref_clk) $fell(i_reset) |->
        !o_infrared_transmit && o_infrared_transmit_oe) else $error("ir not low"); // R1
    pg_tristate_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (mux_q[pin_mux_pkg::MUX_INFRARED_TRANSMIT] && !i_main_power_good) |-> !o_infrared_transmit_oe)
        else $error("ir driven without power"); // R2
    io3_int_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        io3_edge_s |=> status[pin_mux_pkg::ST_IO3]) else $error("io3 lost"); // R5
    io3_no_wake_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !status[pin_mux_pkg::ST_FIXED] && !status[pin_mux_pkg::ST_PROG] |-> !o_wake)
        else $error("wake from io3 or io18"); // R9
    fixed_both_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (fixed_wake_en[0] && $changed(i_fixed_wake[0])) |=> status[pin_mux_pkg::ST_FIXED])
        else $error("fixed edge missed"); // R3
    sci_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_sci_hw_event || sci_sw_q) |-> !o_embedded_sci_out_n) else $error("sci idle"); // R6
    od_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (mux_q[pin_mux_pkg::MUX_OD_GENERAL_OUT_ZERO] && out_q[pin_mux_pkg::OUT_ZERO]) |->
        !o_general_out_zero_oe)
        else $error("od drives high"); // R7
    keyboard_reset_out_block_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        mux_q[pin_mux_pkg::MUX_FLOPPY] |-> o_multi_pin == i_floppy_select_alt)
        else $error("keyboard_reset_out overrode floppy"); // R10
    rtc_src_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        i_rtc_clock_source_select |-> o_rtc_clk == i_crystal_out_or_clock_in)
        else $error("rtc source wrong"); // R8

    // Programmable pin edges on the polarity chosen for bit zero
    sequence prog_rise_s;
        prog_rise[0] && $rose(i_prog_wake[0]);
    endsequence
    sequence prog_fall_s;
        prog_fall[0] && $fell(i_prog_wake[0]);
    endsequence
    // Scan out thirteen edge while switched to io eighteen
    sequence io18_edge_s;
        io18_is_sel && $changed(i_scan_out_thirteen);
    endsequence

    prog_rise_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        prog_rise_s |=> status[pin_mux_pkg::ST_PROG]) else $error("prog rise missed"); // R4
    prog_fall_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        prog_fall_s |=> status[pin_mux_pkg::ST_PROG]) else $error("prog fall missed"); // R4
    // Io eighteen edges reach status but never the wake output
    io18_status_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        io18_edge_s |=> status[pin_mux_pkg::ST_IO18]) else $error("io18 edge lost"); // R9
    // Selected alternate owns the infrared pin
    ir_alt_route_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        mux_q[pin_mux_pkg::MUX_INFRARED_TRANSMIT] |-> o_infrared_transmit == i_infrared_transmit_alt)
        else $error("ir alternate not routed"); // R11
    // Unselected alternate leaves the output register driving
    ir_default_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !mux_q[pin_mux_pkg::MUX_INFRARED_TRANSMIT] |->
        o_infrared_transmit == out_q[pin_mux_pkg::OUT_IR] && o_infrared_transmit_oe)
        else $error("ir default not driven"); // R12
    // Shared pin alternates float while main power is bad
    multi_tristate_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (mux_q[pin_mux_pkg::MUX_FLOPPY] || mux_q[pin_mux_pkg::MUX_KEYBOARD_RESET_OUT]) &&
        !i_main_power_good |-> !o_multi_pin_oe) else $error("shared pin driven"); // R2
    // Keyboard reset reaches the pin once floppy select is off
    keyboard_reset_out_route_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !mux_q[pin_mux_pkg::MUX_FLOPPY] && mux_q[pin_mux_pkg::MUX_KEYBOARD_RESET_OUT] |->
        o_multi_pin == i_keyboard_reset_out) else $error("keyboard_reset_out not routed"); // R10
    // Open-drain io seven never drives high
    od_io7_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (mux_q[pin_mux_pkg::MUX_OD_IO7] && out_q[pin_mux_pkg::OUT_IO7]) |->
        !o_general_io_seven_oe) else $error("io7 od drives high"); // R7
endmodule

// File: test/pin_function_mux_wakeup_tb.sv
// Self-checking testbench for the pin multiplex and wake-up block
module pin_function_mux_wakeup_tb;
    timeunit 1ns;
    timeprecision 100ps;
    //----------------------------------------
    // Stimulus and observed signals
    //----------------------------------------
    logic       i_ref_clk = 1'b0;  // Bench clock
    logic       i_reset   = 1'b1;  // Sync reset
    logic [3:0] i_addr    = 4'h0;  // Register address
    logic [7:0] i_wdata   = 8'h00; // Write data
    logic       i_wr = 1'b0, i_rd = 1'b0, pg = 1'b0, sel = 1'b0, xin = 1'b0, xio = 1'b0;
    logic       ir_alt = 1'b0, fl_alt = 1'b0, kb = 1'b0, io7 = 1'b0, io3 = 1'b0;
    logic       scan = 1'b0, hw = 1'b0;
    logic [3:0] fw = 4'h0, pw = 4'h0; // Wake inputs
    logic [7:0] rdata;                // Read data
    logic [3:0] scan_in;              // Scan pin input path
    logic       rtc, xo, xo_oe, ir, ir_oe, mp, mp_oe, o0, o0_oe, o7, o7_oe, sci_n, wake, irq;
    int         errors    = 0;        // Mismatch count
    int         tests_run = 0;        // Comparison count
    always #5 i_ref_clk = ~i_ref_clk;
    pin_function_mux_wakeup i_dut (
        .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_main_power_good(pg),
        .i_rtc_clock_source_select(sel), .i_crystal_in(xin), .i_crystal_out_or_clock_in(xio),
        .o_rtc_clk(rtc), .o_crystal_out(xo), .o_crystal_out_oe(xo_oe),
        .i_infrared_transmit_alt(ir_alt), .o_infrared_transmit(ir),
        .o_infrared_transmit_oe(ir_oe), .i_floppy_select_alt(fl_alt),
        .i_keyboard_reset_out(kb), .o_multi_pin(mp), .o_multi_pin_oe(mp_oe),
        .i_general_io_seven(io7), .o_general_out_zero(o0), .o_general_out_zero_oe(o0_oe),
        .o_general_io_seven(o7), .o_general_io_seven_oe(o7_oe), .i_fixed_wake(fw),
        .i_prog_wake(pw), .i_general_io_three(io3), .i_scan_out_thirteen(scan),
        .o_scan_io_in(scan_in), .i_sci_hw_event(hw), .o_embedded_sci_out_n(sci_n),
        .o_wake(wake), .o_irq(irq));
    //----------------------------------------
    // Bus and compare helpers
    //----------------------------------------
    // One-cycle write strobe, outputs settled on return
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        #1;
    endtask
    // Byte compare
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Single pin compare
    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read strobe, data sampled in the following cycle only
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_ref_clk);
        i_rd <= 1'b1; i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        chk8(rdata, exp);
    endtask
    // Let edge detection and status capture land
    task automatic cyc3;
        repeat (3) @(posedge i_ref_clk);
        #1;
    endtask
    //----------------------------------------
    // Scenarios
    //----------------------------------------
    // Reset state with main power bad
    task automatic t_reset;
        chk1(ir, 1'b0);
        chk1(ir_oe, 1'b1);
        for (int k = 0; k < 16; k++) begin
            rdc(4'(k), 8'h00);
        end
        rdc(4'h7, 8'h00);
        chk1(irq | wake, 1'b0);
    endtask
    // Infrared pin: output register, then alternate
    task automatic t_ir;
        wr(4'h1, 8'h01);
        chk1(ir, 1'b1);
        wr(4'h0, 8'h01);
        chk1(ir, 1'b0);
        @(posedge i_ref_clk); ir_alt <= 1'b1; #1;
        chk1(ir, 1'b1);
        wr(4'h0, 8'h00);
    endtask
    // Shared pin: default, floppy select, keyboard reset, power loss
    task automatic t_multi;
        wr(4'h1, 8'h02);
        chk1(mp, 1'b1);
        wr(4'h0, 8'h02);
        chk1(mp, 1'b0);
        chk1(mp_oe, 1'b1);
        @(posedge i_ref_clk); pg <= 1'b0; #1;
        chk1(mp_oe, 1'b0);
        @(posedge i_ref_clk); pg <= 1'b1; kb <= 1'b1; #1;
        wr(4'h0, 8'h06);
        chk1(mp, 1'b0);
        wr(4'h0, 8'h04);
        chk1(mp, 1'b1);
        @(posedge i_ref_clk); pg <= 1'b0; #1;
        chk1(mp_oe, 1'b0);
        @(posedge i_ref_clk); pg <= 1'b1; #1;
        wr(4'h0, 8'h00);
    endtask
    // Push-pull versus open-drain, each by its own bit
    task automatic t_od;
        wr(4'h1, 8'hFF);
        chk8({o0, o0_oe, o7, o7_oe}, 8'h0F);
        wr(4'h0, 8'h10);
        chk8({o0_oe, o7_oe}, 8'h01);
        wr(4'h0, 8'h30);
        chk8({o0_oe, o7_oe}, 8'h00);
        wr(4'h1, 8'h00);
        chk8({o0, o0_oe, o7, o7_oe}, 8'h05);
        wr(4'h0, 8'h00);
    endtask
    // Fixed group: both edges, masked per bit
    task automatic t_fixed;
        wr(4'h2, 8'h01);
        wr(4'h7, 8'h01);
        @(posedge i_ref_clk); fw <= 4'h1; cyc3;
        chk8(scan_in, 8'h01);
        rdc(4'h5, 8'h01);
        chk8({wake, irq}, 8'h03);
        wr(4'h7, 8'h00);
        chk1(irq, 1'b0);
        wr(4'h6, 8'h01);
        chk1(wake, 1'b0);
        @(posedge i_ref_clk); fw <= 4'h0; cyc3;
        rdc(4'h5, 8'h01);
        wr(4'h6, 8'h01);
        @(posedge i_ref_clk); fw <= 4'h2; cyc3;
        rdc(4'h5, 8'h00);
        chk1(wake, 1'b0);
    endtask
    // Programmable group: rising, then falling only
    task automatic t_prog;
        wr(4'h2, 8'h10);
        wr(4'h3, 8'h01);
        @(posedge i_ref_clk); pw <= 4'h1; cyc3;
        rdc(4'h5, 8'h02);
        chk1(wake, 1'b1);
        wr(4'h6, 8'h02);
        @(posedge i_ref_clk); pw <= 4'h0; cyc3;
        rdc(4'h5, 8'h00);
        wr(4'h3, 8'h00);
        @(posedge i_ref_clk); pw <= 4'h1; cyc3;
        rdc(4'h5, 8'h00);
        @(posedge i_ref_clk); pw <= 4'h0; cyc3;
        rdc(4'h5, 8'h02);
        wr(4'h6, 8'h0F);
    endtask
    // Io three interrupts only; io eighteen never wakes
    task automatic t_io3_io18;
        wr(4'h2, 8'hFF);
        wr(4'h4, 8'h08);
        wr(4'h7, 8'h04);
        @(posedge i_ref_clk); io3 <= 1'b1; cyc3;
        rdc(4'h5, 8'h04);
        chk8({wake, irq}, 8'h01);
        wr(4'h6, 8'h04);
        chk1(irq, 1'b0);
        wr(4'h4, 8'h00);
        @(posedge i_ref_clk); io3 <= 1'b0; cyc3;
        @(posedge i_ref_clk); io3 <= 1'b1; cyc3;
        rdc(4'h5, 8'h00);
        wr(4'h0, 8'h08);
        @(posedge i_ref_clk); scan <= 1'b1; cyc3;
        rdc(4'h5, 8'h08);
        chk1(wake, 1'b0);
        @(posedge i_ref_clk); scan <= 1'b0; cyc3;
        chk1(wake, 1'b0);
        wr(4'h6, 8'h0F);
        wr(4'h0, 8'h00);
    endtask
    // Sci output from software bit and hardware event
    task automatic t_sci;
        chk1(sci_n, 1'b1);
        wr(4'h8, 8'h01);
        chk1(sci_n, 1'b0);
        wr(4'h8, 8'h00);
        chk1(sci_n, 1'b1);
        @(posedge i_ref_clk); hw <= 1'b1; #1;
        chk1(sci_n, 1'b0);
        @(posedge i_ref_clk); hw <= 1'b0; #1;
    endtask
    // Clock source select, pin readback, refused accesses
    task automatic t_rtc;
        @(posedge i_ref_clk); xin <= 1'b1; #1;
        chk8({rtc, xo, xo_oe}, 8'h05);
        @(posedge i_ref_clk); xin <= 1'b0; sel <= 1'b1; xio <= 1'b1; #1;
        chk8({rtc, xo_oe}, 8'h02);
        @(posedge i_ref_clk); xio <= 1'b0; io7 <= 1'b1; #1;
        chk1(rtc, 1'b0);
        rdc(4'h9, 8'h0F);
        rdc(4'hF, 8'h00);
        wr(4'h5, 8'hFF);
        rdc(4'h5, 8'h00);
    endtask
    //----------------------------------------
    // Verdict, watchdog and main sequence
    //----------------------------------------
    task automatic finish_test;
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Run needs about two hundred cycles
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        errors++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        #1;
        t_reset();
        @(posedge i_ref_clk); pg <= 1'b1;
        t_ir();
        t_multi();
        t_od();
        t_fixed();
        t_prog();
        t_io3_io18();
        t_sci();
        t_rtc();
        finish_test();
    end
endmodule
